// >>> hdl/ibe_consts.svh
`ifndef IBE_CONSTS_SVH
`define IBE_CONSTS_SVH

// ---------------------------------------------------------------
// clock and bus rates
// ---------------------------------------------------------------
`define IBE_CLK_HZ 32'h0098_9680
`define IBE_STD_HZ 32'h0001_86A0
`define IBE_FAST_HZ 32'h0006_1A80

// cycles per scl phase, rounded up so the bus never runs too fast
`define IBE_STD_RELOAD \
  ((`IBE_CLK_HZ + 32'h0000_0002 * `IBE_STD_HZ - 32'h0000_0001) / \
   (32'h0000_0002 * `IBE_STD_HZ))
`define IBE_FAST_RELOAD \
  ((`IBE_CLK_HZ + 32'h0000_0002 * `IBE_FAST_HZ - 32'h0000_0001) / \
   (32'h0000_0002 * `IBE_FAST_HZ))

// ---------------------------------------------------------------
// byte framing and addresses
// ---------------------------------------------------------------
`define IBE_BYTE_BITS 4'h8
`define IBE_GC_ADDR 8'h00
`define IBE_TEN_HDR 5'h1E
`define IBE_WR_MASK 9'h1fe
`define IBE_RD_MASK 9'h001

`endif

// >>> hdl/ibe_pkg.sv
package ibe_pkg;
  // master sequencer states
  typedef enum logic [3:0] {
    M_IDLE, M_STA_HOLD, M_WAIT, M_BIT_LOW, M_BIT_HIGH,
    M_RS_LOW, M_RS_HIGH, M_STOP_LOW, M_STOP_HIGH, M_STOP_REL
  } ibe_mstate_e;

  // slave byte engine states
  typedef enum logic [2:0] {
    S_IDLE, S_RECV, S_ACK, S_STRETCH, S_SEND, S_MACK, S_IGNORE
  } ibe_sstate_e;
endpackage

// >>> hdl/ibe_bus_if.sv
`timescale 1ns/100ps
`default_nettype none

// synchronised bus levels and detected bus conditions
interface ibe_bus_if;
  logic sdaS;
  logic sclS;
  logic sclRise;
  logic sclFall;
  logic start;
  logic repStart;
  logic stop;
  logic busy;

  modport mon (
    output sdaS, sclS, sclRise, sclFall, start, repStart, stop, busy
  );
  modport eng (
    input sdaS, sclS, sclRise, sclFall, start, repStart, stop, busy
  );
endinterface

`default_nettype wire

// >>> hdl/ibe_bus_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module ibe_bus_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sdaIn,
  input wire logic sclIn,
  ibe_bus_if.mon bus
);
  logic sdaMeta, sdaS, sdaPrev, sclMeta, sclS, sclPrev, busy;
  logic next_busy;
  logic startHit, stopHit;

  // ---------------------------------------------------------------
  // condition detection
  // ---------------------------------------------------------------
  // sda edges while scl stays high
  assign startHit = sclS & sclPrev & sdaPrev & ~sdaS;
  assign stopHit = sclS & sclPrev & ~sdaPrev & sdaS;

  // busy from start until stop
  always_comb begin
    next_busy = busy;
    if (stopHit) begin
      next_busy = 1'b0;
    end else if (startHit) begin
      next_busy = 1'b1;
    end
  end

  // two-flop synchronisers, then one stage of history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sdaMeta <= 1'b1;
      sdaS <= 1'b1;
      sdaPrev <= 1'b1;
      sclMeta <= 1'b1;
      sclS <= 1'b1;
      sclPrev <= 1'b1;
      busy <= 1'b0;
    end else begin
      sdaMeta <= sdaIn;
      sdaS <= sdaMeta;
      sdaPrev <= sdaS;
      sclMeta <= sclIn;
      sclS <= sclMeta;
      sclPrev <= sclS;
      busy <= next_busy;
    end
  end

  // outputs to the engine
  assign bus.sdaS = sdaS;
  assign bus.sclS = sclS;
  assign bus.sclRise = sclS & ~sclPrev;
  assign bus.sclFall = ~sclS & sclPrev;
  assign bus.start = startHit;
  assign bus.repStart = startHit & busy;
  assign bus.stop = stopHit;
  assign bus.busy = busy;
endmodule

`default_nettype wire

// >>> hdl/ibe_engine.sv
`timescale 1ns/100ps
`default_nettype none
`include "ibe_consts.svh"


module ibe_engine
  import ibe_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic enable,
  input wire logic fastMode,
  input wire logic startReq,
  input wire logic restartReq,
  input wire logic stopReq,
  input wire logic writeReq,
  input wire logic readReq,
  input wire logic [7:0] txData,
  input wire logic ackBit,
  input wire logic collisionClr,
  output logic masterReady,
  output logic masterEvent,
  output logic [7:0] masterRxData,
  output logic masterAckIn,
  output logic collision,
  input wire logic [9:0] slaveAddr,
  input wire logic [9:0] addrMask,
  input wire logic tenBitMode,
  input wire logic genCallEnable,
  input wire logic repeaterMode,
  input wire logic slaveTxLoad,
  input wire logic [7:0] slaveTxData,
  output logic slaveAddressed,
  output logic slaveRead,
  output logic slaveGenCall,
  output logic [7:0] slaveRxData,
  output logic slaveRxDone,
  output logic slaveTxReq,
  output logic slaveAckIn,
  output logic slaveEvent,
  output logic busBusy,
  output logic busIdle
);
  ibe_bus_if busIf();

  ibe_bus_monitor uMon (
    .clk(clk),
    .resetn(resetn),
    .sdaIn(sdaIn),
    .sclIn(sclIn),
    .bus(busIf)
  );

  // ---------------------------------------------------------------
  // master sequencer
  // ---------------------------------------------------------------
  ibe_mstate_e mState, next_mState;
  logic [7:0] bitRateDivider, next_bitRateDivider;
  logic [7:0] loadVal;
  logic [3:0] mBitCnt, next_mBitCnt;
  logic [8:0] txSh, next_txSh, txMask, next_txMask, rxSh, next_rxSh;
  logic mSda, next_mSda, mScl, next_mScl;
  logic [7:0] next_masterRxData;
  logic next_masterAckIn, next_masterEvent, next_collision;
  logic phaseEnd;

  // phase length from the selected bus rate
  assign loadVal = fastMode ? 8'(`IBE_FAST_RELOAD - 32'h0000_0001)
                            : 8'(`IBE_STD_RELOAD - 32'h0000_0001);
  assign phaseEnd = (bitRateDivider == 8'h00);

  // master next state
  always_comb begin
    next_mState = mState;
    next_bitRateDivider = bitRateDivider - 8'h01;
    next_mBitCnt = mBitCnt;
    next_txSh = txSh;
    next_txMask = txMask;
    next_rxSh = rxSh;
    next_mSda = mSda;
    next_mScl = mScl;
    next_masterRxData = masterRxData;
    next_masterAckIn = masterAckIn;
    next_masterEvent = 1'b0;
    next_collision = collision & ~collisionClr;
    if (phaseEnd) begin
      next_bitRateDivider = 8'h00;
    end
    if (!enable) begin
      next_mState = M_IDLE;
      next_mSda = 1'b0;
      next_mScl = 1'b0;
    end else begin
      unique case (mState)
        M_IDLE: begin
          if (startReq && (busIf.busy || !busIdle)) begin
            next_collision = 1'b1;
          end else if (startReq) begin
            next_mSda = 1'b1;
            next_bitRateDivider = loadVal;
            next_mState = M_STA_HOLD;
          end
        end
        M_STA_HOLD: begin
          if (phaseEnd) begin
            next_mScl = 1'b1;
            next_mState = M_WAIT;
            next_masterEvent = 1'b1;
          end
        end
        M_WAIT: begin
          next_mBitCnt = 4'h0;
          next_bitRateDivider = loadVal;
          if (writeReq) begin
            next_txSh = {txData, 1'b1};
            next_txMask = `IBE_WR_MASK;
            next_mState = M_BIT_LOW;
          end else if (readReq) begin
            next_txSh = {8'hFF, ackBit};
            next_txMask = `IBE_RD_MASK;
            next_mState = M_BIT_LOW;
          end else if (restartReq) begin
            next_mSda = 1'b0;
            next_mState = M_RS_LOW;
          end else if (stopReq) begin
            next_mSda = 1'b1;
            next_mState = M_STOP_LOW;
          end else begin
            next_bitRateDivider = bitRateDivider;
          end
        end
        M_BIT_LOW: begin
          next_mSda = ~txSh[8];
          if (phaseEnd) begin
            next_mScl = 1'b0;
            next_bitRateDivider = loadVal;
            next_mState = M_BIT_HIGH;
          end
        end
        M_BIT_HIGH: begin
          if (!busIf.sclS) begin
            next_bitRateDivider = loadVal;
          end else if (phaseEnd) begin
            next_rxSh = {rxSh[7:0], busIf.sdaS};
            next_bitRateDivider = loadVal;
            next_mScl = 1'b1;
            if (txMask[8] && txSh[8] && !busIf.sdaS) begin
              next_collision = 1'b1;
              next_mSda = 1'b0;
              next_mScl = 1'b0;
              next_mState = M_IDLE;
              next_masterEvent = 1'b1;
            end else if (mBitCnt == `IBE_BYTE_BITS) begin
              next_masterRxData = rxSh[7:0];
              next_masterAckIn = busIf.sdaS;
              next_masterEvent = 1'b1;
              next_mState = M_WAIT;
            end else begin
              next_txSh = {txSh[7:0], 1'b1};
              next_txMask = {txMask[7:0], 1'b0};
              next_mBitCnt = mBitCnt + 4'h1;
              next_mState = M_BIT_LOW;
            end
          end
        end
        M_RS_LOW: begin
          if (phaseEnd) begin
            next_mScl = 1'b0;
            next_bitRateDivider = loadVal;
            next_mState = M_RS_HIGH;
          end
        end
        M_RS_HIGH: begin
          if (!busIf.sclS) begin
            next_bitRateDivider = loadVal;
          end else if (phaseEnd) begin
            next_mSda = 1'b1;
            next_bitRateDivider = loadVal;
            next_mState = M_STA_HOLD;
          end
        end
        M_STOP_LOW: begin
          if (phaseEnd) begin
            next_mScl = 1'b0;
            next_bitRateDivider = loadVal;
            next_mState = M_STOP_HIGH;
          end
        end
        M_STOP_HIGH: begin
          if (!busIf.sclS) begin
            next_bitRateDivider = loadVal;
          end else if (phaseEnd) begin
            next_mSda = 1'b0;
            next_bitRateDivider = loadVal;
            next_mState = M_STOP_REL;
          end
        end
        M_STOP_REL: begin
          if (phaseEnd) begin
            next_masterEvent = 1'b1;
            next_mState = M_IDLE;
          end
        end
      endcase
    end
  end

  // master registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mState <= M_IDLE;
      bitRateDivider <= 8'h00;
      mBitCnt <= 4'h0;
      txSh <= 9'h1ff;
      txMask <= 9'h000;
      rxSh <= 9'h000;
      mSda <= 1'b0;
      mScl <= 1'b0;
      masterRxData <= 8'h00;
      masterAckIn <= 1'b1;
      masterEvent <= 1'b0;
      collision <= 1'b0;
    end else begin
      mState <= next_mState;
      bitRateDivider <= next_bitRateDivider;
      mBitCnt <= next_mBitCnt;
      txSh <= next_txSh;
      txMask <= next_txMask;
      rxSh <= next_rxSh;
      mSda <= next_mSda;
      mScl <= next_mScl;
      masterRxData <= next_masterRxData;
      masterAckIn <= next_masterAckIn;
      masterEvent <= next_masterEvent;
      collision <= next_collision;
    end
  end

  assign masterReady = (mState == M_WAIT) || (mState == M_IDLE);

  // ---------------------------------------------------------------
  // slave byte engine
  // ---------------------------------------------------------------
  ibe_sstate_e sState, next_sState;
  logic [3:0] sBitCnt, next_sBitCnt;
  logic [7:0] sSh, next_sSh, sTxSh, next_sTxSh, next_slaveRxData;
  logic sFirst, next_sFirst, sSecond, next_sSecond;
  logic sTenDone, next_sTenDone;
  logic next_slaveAddressed, next_slaveRead, next_slaveGenCall;
  logic next_slaveRxDone, next_slaveTxReq, next_slaveAckIn;
  logic hiMatch, lo7Match, lo10Match;

  // masked address compares on the collected byte
  assign hiMatch = (sSh[7:3] == `IBE_TEN_HDR) &&
    (((sSh[2:1] ^ slaveAddr[9:8]) & ~addrMask[9:8]) == 2'h0);
  assign lo7Match =
    (((sSh[7:1] ^ slaveAddr[6:0]) & ~addrMask[6:0]) == 7'h00);
  assign lo10Match =
    (((sSh ^ slaveAddr[7:0]) & ~addrMask[7:0]) == 8'h00);

  // slave next state, independent of the master sequencer
  always_comb begin
    logic ackIt;
    ackIt = 1'b0;
    next_sState = sState;
    next_sBitCnt = sBitCnt;
    next_sSh = sSh;
    next_sTxSh = sTxSh;
    next_sFirst = sFirst;
    next_sSecond = sSecond;
    next_sTenDone = sTenDone;
    next_slaveAddressed = slaveAddressed;
    next_slaveRead = slaveRead;
    next_slaveGenCall = slaveGenCall;
    next_slaveRxData = slaveRxData;
    next_slaveRxDone = 1'b0;
    next_slaveTxReq = 1'b0;
    next_slaveAckIn = slaveAckIn;
    if (!enable || busIf.stop) begin
      next_sState = S_IDLE;
      next_sTenDone = 1'b0;
      next_slaveAddressed = 1'b0;
      next_slaveGenCall = 1'b0;
      next_sFirst = 1'b0;
      next_sSecond = 1'b0;
    end else if (busIf.start) begin
      next_sState = S_RECV;
      next_sBitCnt = 4'h0;
      next_sFirst = 1'b1;
      next_sSecond = 1'b0;
      next_slaveAddressed = 1'b0;
      next_slaveGenCall = 1'b0;
    end else begin
      unique case (sState)
        S_IDLE, S_IGNORE: begin
        end
        S_RECV: begin
          if (busIf.sclRise) begin
            next_sSh = {sSh[6:0], busIf.sdaS};
            next_sBitCnt = sBitCnt + 4'h1;
          end else if (busIf.sclFall && sBitCnt == `IBE_BYTE_BITS) begin
            next_sBitCnt = 4'h0;
            next_sFirst = 1'b0;
            next_sSecond = 1'b0;
            if (sFirst) begin
              next_slaveRead = sSh[0];
              if (repeaterMode) begin
                ackIt = 1'b1;
              end else if (tenBitMode) begin
                if (hiMatch && !sSh[0]) begin
                  ackIt = 1'b1;
                  next_sSecond = 1'b1;
                end else if (hiMatch && sTenDone) begin
                  ackIt = 1'b1;
                end
              end else if (lo7Match) begin
                ackIt = 1'b1;
              end
              if (!repeaterMode && genCallEnable &&
                  sSh == `IBE_GC_ADDR) begin
                ackIt = 1'b1;
                next_slaveGenCall = 1'b1;
              end
              next_slaveAddressed = ackIt & ~next_sSecond;
            end else if (sSecond) begin
              if (lo10Match) begin
                ackIt = 1'b1;
                next_sTenDone = 1'b1;
                next_slaveAddressed = 1'b1;
              end
            end else begin
              next_slaveRxData = sSh;
              next_slaveRxDone = 1'b1;
              ackIt = 1'b1;
            end
            next_sState = ackIt ? S_ACK : S_IGNORE;
          end
        end
        S_ACK: begin
          if (busIf.sclFall) begin
            if (slaveRead) begin
              next_sState = S_STRETCH;
              next_slaveTxReq = 1'b1;
            end else begin
              next_sState = S_RECV;
            end
          end
        end
        S_STRETCH: begin
          if (slaveTxLoad) begin
            next_sTxSh = slaveTxData;
            next_sBitCnt = 4'h0;
            next_sState = S_SEND;
          end
        end
        S_SEND: begin
          if (busIf.sclRise) begin
            next_sBitCnt = sBitCnt + 4'h1;
          end else if (busIf.sclFall) begin
            if (sBitCnt == `IBE_BYTE_BITS) begin
              next_sState = S_MACK;
            end else begin
              next_sTxSh = {sTxSh[6:0], 1'b1};
            end
          end
        end
        S_MACK: begin
          if (busIf.sclRise) begin
            next_slaveAckIn = busIf.sdaS;
          end else if (busIf.sclFall) begin
            if (!slaveAckIn) begin
              next_sState = S_STRETCH;
              next_slaveTxReq = 1'b1;
            end else begin
              next_sState = S_IGNORE;
            end
          end
        end
      endcase
    end
  end

  // slave registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sState <= S_IDLE;
      sBitCnt <= 4'h0;
      sSh <= 8'h00;
      sTxSh <= 8'hFF;
      sFirst <= 1'b0;
      sSecond <= 1'b0;
      sTenDone <= 1'b0;
      slaveAddressed <= 1'b0;
      slaveRead <= 1'b0;
      slaveGenCall <= 1'b0;
      slaveRxData <= 8'h00;
      slaveRxDone <= 1'b0;
      slaveTxReq <= 1'b0;
      slaveAckIn <= 1'b1;
    end else begin
      sState <= next_sState;
      sBitCnt <= next_sBitCnt;
      sSh <= next_sSh;
      sTxSh <= next_sTxSh;
      sFirst <= next_sFirst;
      sSecond <= next_sSecond;
      sTenDone <= next_sTenDone;
      slaveAddressed <= next_slaveAddressed;
      slaveRead <= next_slaveRead;
      slaveGenCall <= next_slaveGenCall;
      slaveRxData <= next_slaveRxData;
      slaveRxDone <= next_slaveRxDone;
      slaveTxReq <= next_slaveTxReq;
      slaveAckIn <= next_slaveAckIn;
    end
  end

  assign slaveEvent = slaveRxDone | slaveTxReq;

  // ---------------------------------------------------------------
  // open-drain pins and bus status
  // ---------------------------------------------------------------
  logic next_sdaOe, next_sclOe, next_busIdle;

  // wired-and drive: only pull low or release
  always_comb begin
    // first reply bit goes out a cycle before the stretch lets scl go
    next_sdaOe = mSda | (sState == S_ACK) |
                 ((sState == S_SEND) & ~sTxSh[7]) |
                 ((sState == S_STRETCH) & slaveTxLoad &
                  ~slaveTxData[7]);
    next_sclOe = mScl | (sState == S_STRETCH);
    next_busIdle = ~busIf.busy & busIf.sdaS & busIf.sclS;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      busIdle <= 1'b0;
    end else begin
      sdaOe <= next_sdaOe;
      sclOe <= next_sclOe;
      busIdle <= next_busIdle;
    end
  end

  assign sdaOut = 1'b0;
  assign sclOut = 1'b0;
  assign busBusy = busIf.busy;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  start_order_a: assert property (
    (mState == M_IDLE && next_mState == M_STA_HOLD)
      |=> mSda && !mScl ##1 mSda)
    else $error("start not sda low before scl");
  stop_order_a: assert property (
    (mState == M_STOP_HIGH && next_mState == M_STOP_REL)
      |-> busIf.sclS ##1 !mSda && !mScl)
    else $error("stop not sda release with scl high");
  rs_setup_a: assert property (
    (mState == M_RS_HIGH) |-> !mSda && !mScl)
    else $error("repeated start setup drives lines");
  data_stable_a: assert property (
    (mState == M_BIT_HIGH) |-> $stable(mSda))
    else $error("sda changed during scl high");
  byte_len_a: assert property (
    (mState == M_BIT_HIGH && next_mState == M_WAIT)
      |-> mBitCnt == 4'h8)
    else $error("byte not nine clocks");
  slave_ack_a: assert property (
    (sState == S_ACK) |=> sdaOe)
    else $error("slave ack not driven");
  stretch_wait_a: assert property (
    (mState == M_BIT_HIGH && !busIf.sclS)
      |=> mState == M_BIT_HIGH && bitRateDivider == $past(loadVal))
    else $error("master advanced during stretch");
  busy_start_a: assert property (
    (mState == M_IDLE && enable && startReq && busIf.busy)
      |=> collision && mState == M_IDLE && !mSda)
    else $error("start issued on busy bus");
  slave_stretch_a: assert property (
    (sState == S_STRETCH) |=> sclOe)
    else $error("slave stretch not holding scl");
  collide_a: assert property (
    $rose(collision) && $past(mState) == M_BIT_HIGH
      |-> mState == M_IDLE && !mSda && !mScl)
    else $error("collision did not release bus");

  write_done_c: cover property (
    mState == M_BIT_HIGH && next_mState == M_WAIT && !txMask[0]);
  slave_hit_c: cover property ($rose(slaveAddressed));
  slave_tx_c: cover property (sState == S_STRETCH ##1 sState == S_SEND);
  collision_c: cover property ($rose(collision));
  restart_c: cover property (busIf.repStart);
endmodule

`default_nettype wire

// >>> tb/ibe_far_dev.sv
`timescale 1ns/100ps
`default_nettype none

// far-side slave: acks each byte and may stretch the clock
module ibe_far_dev (
  input wire logic clk,
  input wire logic sda,
  input wire logic scl,
  input wire logic ackOn,
  input wire logic stall,
  input wire logic jamSda,
  output logic pullSda,
  output logic pullScl
);
  logic sdaQ = 1'b1;
  logic sclQ = 1'b1;
  logic [3:0] falls = 4'h0;
  logic [5:0] hold = 6'h00;

  // count clock falls per byte, stretch low phase when stalling
  always @(posedge clk) begin
    sdaQ <= sda;
    sclQ <= scl;
    if (scl && sdaQ && !sda) begin
      falls <= 4'hF;
    end else if (sclQ && !scl) begin
      falls <= (falls == 4'h8) ? 4'h0 : falls + 4'h1;
      if (stall) begin
        hold <= 6'h3F;
      end
    end else if (hold != 6'h00) begin
      hold <= hold - 6'h01;
    end
  end

  // only pull low or release, ack on the ninth bit
  assign pullSda = jamSda | (ackOn && falls == 4'h8);
  assign pullScl = hold != 6'h00;
endmodule

`default_nettype wire

// >>> tb/i2c_bus_protocol_engine_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end

module i2c_bus_protocol_engine_tb;
  logic clk, resetn, enable, fastMode, startReq, restartReq, stopReq;
  logic writeReq, readReq, ackBit, collisionClr, tenBitMode, stall;
  logic genCallEnable, repeaterMode, slaveTxLoad, ackOn, jamSda;
  logic [7:0] txData, slaveTxData, masterRxData, slaveRxData;
  logic [9:0] slaveAddr, addrMask;
  logic sdaOut, sdaOe, sclOut, sclOe, masterReady, masterEvent, masterAckIn;
  logic collision, slaveAddressed, slaveRead, slaveGenCall, slaveRxDone;
  logic slaveTxReq, slaveAckIn, slaveEvent, busBusy, busIdle;
  logic pullSda, pullScl;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  // wired-and bus with pull-ups
  wire logic sdaIn = !(sdaOe | pullSda);
  wire logic sclIn = !(sclOe | pullScl);

  ibe_engine i_dut (.clk, .resetn, .sdaIn, .sdaOut, .sdaOe, .sclIn, .sclOut,
    .sclOe, .enable, .fastMode, .startReq, .restartReq, .stopReq, .writeReq,
    .readReq, .txData, .ackBit, .collisionClr, .masterReady, .masterEvent,
    .masterRxData, .masterAckIn, .collision, .slaveAddr, .addrMask,
    .tenBitMode, .genCallEnable, .repeaterMode, .slaveTxLoad, .slaveTxData,
    .slaveAddressed, .slaveRead, .slaveGenCall, .slaveRxData, .slaveRxDone,
    .slaveTxReq, .slaveAckIn, .slaveEvent, .busBusy, .busIdle);
  ibe_far_dev i_far (.clk, .sda(sdaIn), .scl(sclIn), .ackOn, .stall,
    .jamSda, .pullSda, .pullScl);

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one master command, wait for its completion pulse
  task automatic op(input logic [4:0] r, input logic [7:0] d);
    int n;
    n = 0;
    txData = d;
    {startReq, restartReq, stopReq, writeReq, readReq} = r;
    @(negedge clk);
    {startReq, restartReq, stopReq, writeReq, readReq} = 5'h00;
    while (masterEvent !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    `CHK(n < 3000, 1'b1)
    `CHK(masterReady, 1'b1)
  endtask

  // start, address byte, stop
  task automatic msg(input logic [7:0] a, input logic ack, input logic hit);
    op(5'h10, 8'h00);
    op(5'h02, a);
    `CHK(masterAckIn, ack)
    `CHK(slaveAddressed | slaveGenCall, hit)
    op(5'h04, 8'h00);
    repeat (4) @(negedge clk);
    `CHK(busIdle, 1'b1)
  endtask

  task automatic t_xfer();
    int n;
    op(5'h10, 8'h00);
    `CHK(busBusy, 1'b1)
    op(5'h02, 8'h54);
    `CHK(masterRxData, 8'h54)
    op(5'h02, 8'hA5);
    `CHK(slaveRxData, 8'hA5)
    op(5'h08, 8'h00);
    op(5'h02, 8'h55);
    `CHK(slaveRead, 1'b1)
    n = 0;
    while (slaveEvent !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK({slaveTxReq, slaveRxDone}, 2'h2)
    repeat (40) @(negedge clk);
    `CHK(sclOe, 1'b1)
    slaveTxData = 8'h3C;
    slaveTxLoad = 1'b1;
    @(negedge clk);
    slaveTxLoad = 1'b0;
    op(5'h01, 8'h00);
    `CHK(masterRxData, 8'h3C)
    `CHK(slaveAckIn, 1'b1)
    op(5'h04, 8'h00);
    $display("test xfer done");
  endtask

  task automatic t_addr();
    {fastMode, ackOn, stall} = 3'h3;
    msg(8'hA0, 1'b0, 1'b0); // slow rate, far side stretches
    {fastMode, ackOn, stall} = 3'h4;
    msg(8'hA0, 1'b1, 1'b0); // nobody answers
    addrMask = 10'h003;
    msg(8'h52, 1'b0, 1'b1); // masked low bits
    genCallEnable = 1'b1;
    msg(8'h00, 1'b0, 1'b1); // general call
    repeaterMode = 1'b1;
    msg(8'hA0, 1'b0, 1'b1); // repeater takes all
    repeaterMode = 1'b0;
    // ten-bit address: header byte, then low address byte
    tenBitMode = 1'b1;
    op(5'h10, 8'h00);
    op(5'h02, 8'hF0);
    `CHK({masterAckIn, slaveAddressed}, 2'h0)
    op(5'h02, 8'h2A);
    `CHK({masterAckIn, slaveAddressed}, 2'h1)
    op(5'h04, 8'h00);
    tenBitMode = 1'b0;
    $display("test addr done");
  endtask

  task automatic t_col();
    jamSda = 1'b1;
    repeat (4) @(negedge clk);
    startReq = 1'b1;
    @(negedge clk);
    startReq = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(collision, 1'b1)
    `CHK({sdaOut, sclOut, sclOe}, 3'h0)
    jamSda = 1'b0;
    collisionClr = 1'b1;
    @(negedge clk);
    collisionClr = 1'b0;
    @(negedge clk);
    `CHK(collision, 1'b0)
    // lost arbitration: other master holds sda low against our ones
    repeat (4) @(negedge clk);
    op(5'h10, 8'h00);
    jamSda = 1'b1;
    op(5'h02, 8'hFF);
    `CHK({collision, masterReady}, 2'h3)
    repeat (3) @(negedge clk);
    `CHK({sdaOe, sclOe}, 2'h0)
    jamSda = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(busIdle, 1'b1)
    collisionClr = 1'b1;
    @(negedge clk);
    collisionClr = 1'b0;
    @(negedge clk);
    `CHK(collision, 1'b0)
    $display("test col done");
  endtask

  // reset, then the scenarios
  initial begin
    resetn = 1'b0;
    {startReq, restartReq, stopReq, writeReq, readReq} = 5'h00;
    {collisionClr, tenBitMode, genCallEnable, repeaterMode} = 4'h0;
    {slaveTxLoad, ackOn, stall, jamSda} = 4'h0;
    {enable, fastMode, ackBit} = 3'h7;
    txData = 8'h00;
    slaveTxData = 8'h00;
    slaveAddr = 10'h02A;
    addrMask = 10'h000;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_xfer();
    t_addr();
    t_col();
    conclude();
  end
endmodule

`default_nettype wire
